// File: src/acr_cfg.svh
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// Register offsets on the byte register port
`define ACR_OFF_ISEL   3'h0
`define ACR_OFF_CTLA   3'h1
`define ACR_OFF_CTLB   3'h2
`define ACR_OFF_RESL   3'h3
`define ACR_OFF_RESH   3'h4

// Bit positions in adc_input_select
`define ACR_ISEL_LALIGN 5

// Bit positions in adc_control_a
`define ACR_CTLA_EN    7
`define ACR_CTLA_SC    6
`define ACR_CTLA_ATE   5
`define ACR_CTLA_IF    4
`define ACR_CTLA_IE    3

// Bit positions in adc_control_b
`define ACR_CTLB_HSM   7
`define ACR_CTLB_CURRENT_SOURCE_INPUT  6
`define ACR_CTLB_REFERENCE_PIN  5

// Reset value of every byte register
`define ACR_RST_BYTE   8'h00

// Channel codes: last legal code is ground
`define ACR_CH_GND     5'h12

// Trigger source codes
`define ACR_TRIG_FREE  4'h0
`define ACR_TRIG_LAST  4'hd
`define ACR_NUM_TRIG   13

// Reference select code of the internal reference
`define ACR_REF_INT    2'h3

`endif

// File: src/acr_pkg.sv
package acr_pkg;

  // Conversion tracking state
  typedef enum logic [0:0] {
    ACR_IDLE = 1'b0,
    ACR_BUSY = 1'b1
  } acr_conv_t;

  // Prescaler selection code
  typedef logic [2:0] acr_presc_t;

endpackage

// File: src/acr_presc_if.sv
`timescale 1ns/1ps
// Link between the control logic and the clock prescaler
interface acr_presc_if;
  logic [2:0] sel;   // Division code
  logic       run;   // Converter enabled
  logic       tick;  // One pulse per converter clock period
  modport ctrl (output sel, output run, input tick);
  modport presc (input sel, input run, output tick);
endinterface : acr_presc_if

// File: src/acr_prescaler.sv
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_prescaler
  import acr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  acr_presc_if.presc pif
);

  logic [6:0] cnt_r;    // Position inside the divided period
  logic [6:0] cnt_nxt;
  logic       tick_r;   // Registered converter clock tick
  logic       tick_nxt;
  logic [6:0] limit;    // Divisor minus one

  // Divisor: codes 0 and 1 give 2, each later code doubles
  always_comb begin
    if (pif.sel <= 3'h1) begin
      limit = 7'h01;  // see R12
    end else begin
      limit = 7'((8'h01 << pif.sel) - 8'h01);  // see R12
    end
    cnt_nxt  = 7'h00;
    tick_nxt = 1'b0;
    // Stopped converter holds the divider in phase zero
    if (pif.run) begin
      if (cnt_r >= limit) begin
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 7'h01;
      end
    end
  end

  // Divider registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign pif.tick = tick_r;

endmodule // acr_prescaler

// File: src/acr_ctrl.sv
// What this block does
// R1: Bits 7:6 select reference; code 10 reserved
// R2: Reference change waits for running conversion end
// R3: Bit 5 left-aligns result reads immediately
// R4: Channel codes 0-18 route inputs; rest reserved
// R5: Channel change waits for running conversion end
// R6: Enable bit; clearing waits for conversion end
// R7: Start bit begins conversion, hardware clears it
// R8: First conversion after enable initializes converter
// R9: Auto-trigger bit uses control B trigger source
// R10: Done flag set; cleared by vector or one
// R11: Interrupt enable gates end-of-conversion request
// R12: Prescaler divides clock by 2 up to 128
// R13: Control B bit 7 drives high-speed mode
// R14: Control B bit 6 enables reference current source
// R15: Control B bit 5 connects internal reference pin
// R16: Control B bit 4 always reads zero
// R17: Internal reference on when converter needs it
// R18: Result split into high and low registers
// R19: Low read locks result until high read
// R20: Auto-trigger starts on selected flag rising edge
// R21: Byte registers, writes act next clock edge
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_ctrl
  import acr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_result,
  input  wire logic [12:0] trig_flags,
  input  wire logic        irq_ack,
  output logic             conv_start,
  output logic             conv_init,
  output logic      [4:0]  chan_sel,
  output logic      [1:0]  ref_sel,
  output logic             converter_on,
  output logic             int_ref_on,
  output logic             high_speed,
  output logic             current_source_en,
  output logic             ref_pin_en,
  output logic             conv_clk_tick,
  output logic             irq_req
);

  // Software-visible register fields
  logic [7:0]  isel_r, isel_nxt;     // adc_input_select as written
  logic        en_r, en_nxt;         // converter_enable as written
  logic        ate_r, ate_nxt;       // auto_trigger_enable
  logic        flag_r, flag_nxt;     // conversion_done_flag
  logic        ie_r, ie_nxt;         // conversion_irq_enable
  acr_presc_t  presc_r, presc_nxt;   // prescale_sel
  logic [2:0]  ctlb_hi_r, ctlb_hi_nxt; // Speed, current source, ref pin
  logic [3:0]  tsel_r, tsel_nxt;     // trigger_source_sel

  // Applied values seen by the analog side
  logic        en_act_r, en_act_nxt;
  logic [4:0]  ch_act_r, ch_act_nxt;
  logic [1:0]  ref_act_r, ref_act_nxt;

  // Conversion tracking
  acr_conv_t   state_r, state_nxt;
  logic        first_r, first_nxt;   // Initialization still owed
  logic        start_r, start_nxt;
  logic        init_r, init_nxt;
  logic [12:0] trig_prev_r;          // Last sampled trigger flags
  logic [12:0] trig_rise;

  // Result and its read lock
  logic [9:0]  res_r, res_nxt;
  logic        lock_r, lock_nxt;

  // Registered outputs
  logic [7:0]  rdata_r, rdata_nxt;
  logic [4:0]  chan_r, chan_nxt;
  logic        iref_r, iref_nxt;
  logic        irq_r, irq_nxt;

  // Decode strobes
  logic        wr_isel, wr_a, wr_b, rd_l, rd_h;
  logic        trig_hit;             // Selected source rose
  logic        free_run;             // Auto mode without a source
  logic        apply;                // Deferred fields may change

  acr_presc_if pif ();
  // Clock divider for the converter
  acr_prescaler u_presc (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pif      (pif)
  );

  assign pif.sel = presc_r;   // see R12
  assign pif.run = en_act_r;

  // Address decode of the byte register port
  always_comb begin
    wr_isel = 1'b0;
    wr_a    = 1'b0;
    wr_b    = 1'b0;
    rd_l    = 1'b0;
    rd_h    = 1'b0;
    if (reg_addr == `ACR_OFF_ISEL) begin
      wr_isel = reg_wr;
    end else if (reg_addr == `ACR_OFF_CTLA) begin
      wr_a = reg_wr;
    end else if (reg_addr == `ACR_OFF_CTLB) begin
      wr_b = reg_wr;
    end else if (reg_addr == `ACR_OFF_RESL) begin
      rd_l = reg_rd;
    end else if (reg_addr == `ACR_OFF_RESH) begin
      rd_h = reg_rd;
    end
  end

  // Edge of the selected trigger flag; interrupt enables do not matter
  always_comb begin
    trig_rise = trig_flags & ~trig_prev_r;
    trig_hit  = 1'b0;
    if (tsel_r != `ACR_TRIG_FREE && tsel_r <= `ACR_TRIG_LAST) begin
      trig_hit = trig_rise[4'(tsel_r - 4'h1)];  // see R20
    end
    free_run = ate_r && (tsel_r == `ACR_TRIG_FREE);  // see R9
  end

  // Register writes, start logic and deferred application
  always_comb begin
    isel_nxt    = isel_r;
    en_nxt      = en_r;
    ate_nxt     = ate_r;
    ie_nxt      = ie_r;
    presc_nxt   = presc_r;
    ctlb_hi_nxt = ctlb_hi_r;
    tsel_nxt    = tsel_r;
    flag_nxt    = flag_r;
    state_nxt   = state_r;
    first_nxt   = first_r;
    start_nxt   = 1'b0;
    init_nxt    = 1'b0;
    // Plain byte writes take effect at the next edge
    if (wr_isel) begin
      isel_nxt = reg_wdata;  // see R21
    end
    if (wr_a) begin
      en_nxt    = reg_wdata[`ACR_CTLA_EN];   // see R6
      ate_nxt   = reg_wdata[`ACR_CTLA_ATE];  // see R9
      ie_nxt    = reg_wdata[`ACR_CTLA_IE];   // see R11
      presc_nxt = reg_wdata[2:0];
    end
    if (wr_b) begin
      ctlb_hi_nxt = reg_wdata[7:5];
      tsel_nxt    = reg_wdata[3:0];
    end
    // Flag clears by writing one or by the vector; a new done wins
    if ((wr_a && reg_wdata[`ACR_CTLA_IF]) || irq_ack) begin
      flag_nxt = 1'b0;  // see R10
    end
    if (conv_done) begin
      flag_nxt = 1'b1;  // see R10
    end
    // Fields that must not move under a running conversion
    apply       = (state_r == ACR_IDLE) || conv_done;
    en_act_nxt  = apply ? en_nxt : en_act_r;            // see R6
    ch_act_nxt  = apply ? isel_nxt[4:0] : ch_act_r;     // see R5
    ref_act_nxt = apply ? isel_nxt[7:6] : ref_act_r;    // see R2
    // Owe an initialization on every enable rise
    if (en_act_nxt && !en_act_r) begin
      first_nxt = 1'b1;  // see R8
    end
    // Conversion sequencing; writing zero to start does nothing
    case (state_r)
      ACR_IDLE: begin
        if (en_nxt && ((wr_a && reg_wdata[`ACR_CTLA_SC]) ||
                       (ate_r && trig_hit))) begin
          state_nxt = ACR_BUSY;  // see R7
          start_nxt = 1'b1;
        end
      end
      ACR_BUSY: begin
        if (conv_done) begin
          if (free_run && en_nxt) begin
            start_nxt = 1'b1;      // see R9
          end else begin
            state_nxt = ACR_IDLE;  // see R7
          end
        end
      end
      default: begin
        state_nxt = ACR_IDLE;
      end
    endcase
    if (start_nxt) begin
      init_nxt  = first_nxt;  // see R8
      first_nxt = 1'b0;
    end
  end

  // Result capture, read lock and output shaping
  always_comb begin
    res_nxt  = res_r;
    lock_nxt = lock_r;
    // A locked pair drops the new result rather than tearing it
    if (conv_done && !lock_r && !rd_l) begin
      res_nxt = conv_result;  // see R18
    end
    if (rd_l) begin
      lock_nxt = 1'b1;  // see R19
    end else if (rd_h) begin
      lock_nxt = 1'b0;  // see R19
    end
    // Reserved channel codes park the input on ground
    chan_nxt = (ch_act_nxt > `ACR_CH_GND) ? `ACR_CH_GND : ch_act_nxt;  // see R4
    iref_nxt = en_act_nxt && (ref_act_nxt == `ACR_REF_INT);  // see R17
    irq_nxt  = flag_nxt && ie_nxt;  // see R11
    // Read mux; alignment is applied at read time
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `ACR_OFF_ISEL) begin
        rdata_nxt = isel_r;  // see R1
      end else if (reg_addr == `ACR_OFF_CTLA) begin
        rdata_nxt = {en_r, (state_r == ACR_BUSY), ate_r, flag_r,
                     ie_r, presc_r};
      end else if (reg_addr == `ACR_OFF_CTLB) begin
        rdata_nxt = {ctlb_hi_r, 1'b0, tsel_r};  // see R16
      end else if (reg_addr == `ACR_OFF_RESL) begin
        rdata_nxt = isel_r[`ACR_ISEL_LALIGN] ?
                    {res_r[1:0], 6'h00} : res_r[7:0];  // see R3
      end else if (reg_addr == `ACR_OFF_RESH) begin
        rdata_nxt = isel_r[`ACR_ISEL_LALIGN] ?
                    res_r[9:2] : {6'h00, res_r[9:8]};  // see R3
      end
    end
  end

  // All state registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      isel_r      <= `ACR_RST_BYTE;
      en_r        <= 1'b0;
      ate_r       <= 1'b0;
      flag_r      <= 1'b0;
      ie_r        <= 1'b0;
      presc_r     <= 3'h0;
      ctlb_hi_r   <= 3'h0;
      tsel_r      <= 4'h0;
      en_act_r    <= 1'b0;
      ch_act_r    <= 5'h00;
      ref_act_r   <= 2'h0;
      state_r     <= ACR_IDLE;
      first_r     <= 1'b0;
      start_r     <= 1'b0;
      init_r      <= 1'b0;
      trig_prev_r <= 13'h0000;
      res_r       <= 10'h000;
      lock_r      <= 1'b0;
      rdata_r     <= 8'h00;
      chan_r      <= 5'h00;
      iref_r      <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      isel_r      <= isel_nxt;
      en_r        <= en_nxt;
      ate_r       <= ate_nxt;
      flag_r      <= flag_nxt;
      ie_r        <= ie_nxt;
      presc_r     <= presc_nxt;
      ctlb_hi_r   <= ctlb_hi_nxt;
      tsel_r      <= tsel_nxt;
      en_act_r    <= en_act_nxt;
      ch_act_r    <= ch_act_nxt;
      ref_act_r   <= ref_act_nxt;
      state_r     <= state_nxt;
      first_r     <= first_nxt;
      start_r     <= start_nxt;
      init_r      <= init_nxt;
      trig_prev_r <= trig_flags;
      res_r       <= res_nxt;
      lock_r      <= lock_nxt;
      rdata_r     <= rdata_nxt;
      chan_r      <= chan_nxt;
      iref_r      <= iref_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign conv_start        = start_r;
  assign conv_init         = init_r;
  assign chan_sel          = chan_r;
  assign ref_sel           = ref_act_r;
  assign converter_on      = en_act_r;
  assign int_ref_on        = iref_r;
  assign high_speed        = ctlb_hi_r[2];  // see R13
  assign current_source_en = ctlb_hi_r[1];  // see R14
  assign ref_pin_en        = ctlb_hi_r[0];  // see R15
  assign conv_clk_tick     = pif.tick;
  assign irq_req           = irq_r;

  // Checks on the behaviour above
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_flag_set;
    conv_done |=> flag_r ##1 (flag_r || $past(irq_ack || wr_a));
  endproperty
  a_flag_set: assert property (p_flag_set)  // see R10
    else $error("done flag not set after completion");
  property p_irq_gate;
    irq_req == (flag_r && ie_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate)  // see R11
    else $error("interrupt request not gated by enable");
  property p_ref_hold;
    (state_r == ACR_BUSY) && !conv_done |=> $stable(ref_sel);
  endproperty
  a_ref_hold: assert property (p_ref_hold)  // see R2
    else $error("reference changed during conversion");
  property p_chan_hold;
    (state_r == ACR_BUSY) && !conv_done |=> $stable(chan_sel);
  endproperty
  a_chan_hold: assert property (p_chan_hold)  // see R5
    else $error("channel changed during conversion");
  property p_en_hold;
    (state_r == ACR_BUSY) && !conv_done |=> converter_on;
  endproperty
  a_en_hold: assert property (p_en_hold)  // see R6
    else $error("converter disabled during conversion");
  property p_single_end;
    (state_r == ACR_BUSY) && conv_done && !ate_r
      |=> state_r == ACR_IDLE;
  endproperty
  a_single_end: assert property (p_single_end)  // see R7
    else $error("start bit not cleared at completion");
  property p_lock;
    lock_r && conv_done |=> $stable(res_r);
  endproperty
  a_lock: assert property (p_lock)  // see R19
    else $error("result updated while locked");
  property p_ctlb_zero;
    reg_rd && reg_addr == `ACR_OFF_CTLB |=> !reg_rdata[4];
  endproperty
  a_ctlb_zero: assert property (p_ctlb_zero)  // see R16
    else $error("reserved control B bit read as one");
  property p_left;
    reg_rd && reg_addr == `ACR_OFF_RESH && isel_r[`ACR_ISEL_LALIGN]
      |=> reg_rdata == $past(res_r[9:2]);
  endproperty
  a_left: assert property (p_left)  // see R3
    else $error("left aligned high byte wrong");
  property p_init;
    conv_init |-> conv_start;
  endproperty
  a_init: assert property (p_init)  // see R8
    else $error("initialization without start");

  c_sw_start: cover property (wr_a && reg_wdata[`ACR_CTLA_SC] ##1 conv_start);
  c_trig_start: cover property (ate_r && trig_hit ##1 conv_start);
  c_lock_drop: cover property (lock_r && conv_done);
  c_free_run: cover property (free_run && conv_done ##1 conv_start);

endmodule // acr_ctrl

// File: bench/acr_core_model.sv
`timescale 1ns/1ps
// Analog core stand-in: answers each start after a set latency
module acr_core_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       conv_start,
  input  wire logic [7:0] lat,
  input  wire logic [9:0] value,
  output logic            conv_done,
  output logic      [9:0] conv_result
);
  logic [7:0] cnt_r;   // Cycles left, zero while idle
  logic [9:0] last_r;  // Last result handed back

  // Count the conversion down; latency 1 answers promptly
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r     <= 8'h00;
      conv_done <= 1'b0;
      last_r    <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        cnt_r <= lat;
      end else if (cnt_r == 8'h01) begin
        cnt_r     <= 8'h00;
        conv_done <= 1'b1;
        last_r    <= value;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // Outside done the bus shows the inverse, so stale capture is caught
  assign conv_result = conv_done ? last_r : ~last_r;
endmodule // acr_core_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "acr_cfg.svh"
module tb_top;
  logic        core_clk   = 1'b0;
  logic        reset_n    = 1'b0;
  logic [2:0]  reg_addr   = 3'h0;
  logic [7:0]  reg_wdata  = 8'h00;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [12:0] trig_flags = 13'h0000;
  logic        irq_ack    = 1'b0;
  logic [7:0]  lat        = 8'h14;
  logic [9:0]  value      = 10'h270;
  logic [7:0]  reg_rdata, rv;
  logic [9:0]  conv_result;
  logic [4:0]  chan_sel;
  logic [1:0]  ref_sel;
  logic        conv_done, conv_start, conv_init, converter_on;
  logic        int_ref_on, high_speed, current_source_en, ref_pin_en;
  logic        conv_clk_tick, irq_req;
  int fails = 0, n_checks = 0, n_start = 0, n_init = 0, n_done = 0;
  int gap = 0, cnt = 0, cyc = 0, k;

  always #12.5 core_clk = ~core_clk;

  acr_ctrl u_acr_ctrl (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_result(conv_result), .trig_flags(trig_flags),
    .irq_ack(irq_ack), .conv_start(conv_start), .conv_init(conv_init),
    .chan_sel(chan_sel), .ref_sel(ref_sel), .converter_on(converter_on),
    .int_ref_on(int_ref_on), .high_speed(high_speed),
    .current_source_en(current_source_en), .ref_pin_en(ref_pin_en),
    .conv_clk_tick(conv_clk_tick), .irq_req(irq_req));

  acr_core_model u_acr_core_model (
    .core_clk(core_clk), .reset_n(reset_n), .conv_start(conv_start),
    .lat(lat), .value(value), .conv_done(conv_done),
    .conv_result(conv_result));

  // Event counters, tick spacing and the hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) n_start <= n_start + 1;
    if (conv_init === 1'b1) n_init <= n_init + 1;
    if (conv_done === 1'b1) n_done <= n_done + 1;
    if (conv_clk_tick === 1'b1) begin
      gap <= cnt + 1;
      cnt <= 0;
    end else cnt <= cnt + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    // Step past the write edge so registered outputs are settled
    #1;
  endtask

  // Data is taken in the single cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic chk_reg(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    n_checks++;
    if (rv !== e) begin
      fails++;
      $display("CHECK FAILED %0t reg %0d got %h exp %h", $time, a, rv, e);
    end
  endtask

  task automatic chk_out(input logic [9:0] g, input logic [9:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t port got %h exp %h", $time, g, e);
    end
  endtask

  // Bounded wait for the given done count, then let outputs settle
  task automatic wdone(input int n);
    repeat (600) if (n_done < n) @(posedge core_clk);
    @(posedge core_clk);
    #1 chk_out(10'(n_done >= n), 10'h001);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 6; a++) chk_reg(3'(a), 8'h00);
    wr(3'h5, 8'hff);
    chk_reg(3'h5, 8'h00);
    wr(`ACR_OFF_CTLB, 8'hff);
    chk_reg(`ACR_OFF_CTLB, 8'hef);
    chk_out(10'({high_speed, current_source_en, ref_pin_en}), 10'h7);
    // Every channel and reference code while idle
    for (int c = 0; c < 32; c++) begin
      wr(`ACR_OFF_ISEL, {2'(c), 1'b0, 5'(c)});
      chk_out(10'(chan_sel), (c > 18) ? 10'(`ACR_CH_GND) : 10'(c));
      chk_out(10'(ref_sel), 10'(c % 4));
    end
    // Divider spacing for all eight codes
    for (int p = 0; p < 8; p++) begin
      wr(`ACR_OFF_CTLA, 8'h80 | 8'(p));
      repeat (300) @(posedge core_clk);
      #1 chk_out(10'(gap), (p < 2) ? 10'h2 : 10'(1 << p));
    end
    wr(`ACR_OFF_CTLB, 8'h00);
    wr(`ACR_OFF_ISEL, 8'h45);
    chk_out(10'(int_ref_on), 10'h0);
    wr(`ACR_OFF_ISEL, 8'hc5);
    chk_out(10'(int_ref_on), 10'h1);
    wr(`ACR_OFF_CTLA, 8'hc9);
    chk_reg(`ACR_OFF_CTLA, 8'hc9);
    chk_out(10'(n_init), 10'h1);
    // Selection writes mid-conversion wait for its end
    wr(`ACR_OFF_ISEL, 8'h47);
    chk_out(10'(chan_sel), 10'h5);
    chk_out(10'(ref_sel), 10'h3);
    wdone(1);
    chk_out(10'({ref_sel, chan_sel}), 10'h27);
    chk_reg(`ACR_OFF_CTLA, 8'h99);
    chk_out(10'(irq_req), 10'h1);
    wr(`ACR_OFF_CTLA, 8'h81);
    chk_out(10'(irq_req), 10'h0);
    wr(`ACR_OFF_CTLA, 8'h91);
    chk_reg(`ACR_OFF_CTLA, 8'h81);
    chk_reg(`ACR_OFF_RESL, 8'h70);
    chk_reg(`ACR_OFF_RESH, 8'h02);
    wr(`ACR_OFF_ISEL, 8'h67);
    chk_reg(`ACR_OFF_RESL, 8'h00);
    chk_reg(`ACR_OFF_RESH, 8'h9c);
    // Low read locks; a result landing meanwhile is dropped
    rd(`ACR_OFF_RESL);
    value <= 10'h155;
    wr(`ACR_OFF_CTLA, 8'hc1);
    wdone(2);
    chk_reg(`ACR_OFF_RESH, 8'h9c);
    chk_out(10'(n_init), 10'h1);
    @(posedge core_clk) irq_ack <= 1'b1;
    @(posedge core_clk) irq_ack <= 1'b0;
    chk_reg(`ACR_OFF_CTLA, 8'h81);
    wr(`ACR_OFF_CTLA, 8'hc1);
    wdone(3);
    chk_reg(`ACR_OFF_RESL, 8'h40);
    chk_reg(`ACR_OFF_RESH, 8'h55);
    // Disable during a conversion lands only at its end
    wr(`ACR_OFF_CTLA, 8'hd1);
    wr(`ACR_OFF_CTLA, 8'h01);
    chk_out(10'(converter_on), 10'h1);
    chk_reg(`ACR_OFF_CTLA, 8'h41);
    wdone(4);
    chk_out(10'(converter_on), 10'h0);
    // Each trigger source: others rise first, then the chosen one
    wr(`ACR_OFF_CTLA, 8'hb1);
    for (int t = 1; t < 14; t++) begin
      wr(`ACR_OFF_CTLB, 8'(t));
      k = n_start;
      @(posedge core_clk) trig_flags <= ~(13'h1 << (t - 1));
      repeat (4) @(posedge core_clk);
      trig_flags <= 13'h1fff;
      repeat (8) @(posedge core_clk);
      #1 chk_out(10'(n_start - k), 10'h001);
      wdone(n_done + 1);
      @(posedge core_clk) trig_flags <= 13'h0000;
    end
    // Reserved trigger code 14 never starts a conversion
    wr(`ACR_OFF_CTLB, 8'h0e);
    k = n_start;
    @(posedge core_clk) trig_flags <= 13'h1fff;
    repeat (8) @(posedge core_clk);
    #1 chk_out(10'(n_start - k), 10'h000);
    @(posedge core_clk) trig_flags <= 13'h0000;
    // Free running with a prompt core, then back to single mode
    lat <= 8'h01;
    wr(`ACR_OFF_CTLB, 8'h00);
    wr(`ACR_OFF_CTLA, 8'he1);
    k = n_done;
    repeat (200) @(posedge core_clk);
    #1 chk_out(10'(n_done - k > 20), 10'h001);
    wr(`ACR_OFF_CTLA, 8'h81);
    repeat (20) @(posedge core_clk);
    k = n_start;
    repeat (100) @(posedge core_clk);
    #1 chk_out(10'(n_start - k), 10'h000);
    // Reset in mid-run brings every register back to zero
    @(posedge core_clk) reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    chk_reg(`ACR_OFF_CTLA, 8'h00);
    chk_reg(`ACR_OFF_ISEL, 8'h00);
    chk_out(10'({converter_on, chan_sel}), 10'h000);
    end_of_test;
  end
endmodule // tb_top
